//--- rxbb_params.svh
// timing, field and reset constants of the dual-path receive baseband
`ifndef RXBB_PARAMS_SVH
`define RXBB_PARAMS_SVH
`define RXBB_SAMPLE_W 8
`define RXBB_RSSI_W 8
`define RXBB_FOFS_W 8
`define RXBB_PAT_W 32
`define RXBB_PAT_LEN_W 6
`define RXBB_RSSI_DEPTH 16
`define RXBB_CRC_POLY 8'h07
`define RXBB_CRC_INIT 8'hff
`define RXBB_SYM_DIV 16'h0010
`endif

//--- rxbb_pkg.sv
// types of the dual-path receive baseband
`include "rxbb_params.svh"
package rxbb_pkg;
  typedef enum logic [2:0] {
    RXBB_HUNT = 3'b001,
    RXBB_PAYLOAD = 3'b010,
    RXBB_HOLD = 3'b100
  } rxbb_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] crc;
    logic path;
    logic temp;
  } rxbb_byte_s;

  typedef struct packed {
    logic signal_ok;
    logic [`RXBB_FOFS_W-1:0] freqOffset;
    logic [`RXBB_RSSI_W-1:0] rssi;
  } rxbb_check_s;
endpackage

//--- rxbb_baseband.sv
// dual-path receive baseband: demod, frame sync, byte buffer, path select, rssi store
// Function
// - one channel filter output drives both receive paths together
// - each path: ask/fsk demod with checks, pattern sync, byte buffer with crc
// - signal checks choose one path feeding data fifo and optional id check
// - rssi values pass a buffer into support fifo holding latest sixteen
// - each path shows its raw demodulated symbols on its own pin
// - decoded bits leave on a serial pin with a bit clock pin
// - each path reports frequency offset from centre frequency
// - when configured, temperature sensor result replaces received data
// - manchester takes two symbols per bit, nrz one symbol per bit
// - payload starts when configured start pattern of up to 32 symbols matches
`timescale 1ns/1ps
`default_nettype none
`include "rxbb_params.svh"
module rxbb_baseband
  import rxbb_pkg::*;
#(
  parameter int SAMPLE_W = `RXBB_SAMPLE_W,
  parameter int RSSI_DEPTH = `RXBB_RSSI_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic filtValid,
  input wire logic signed [SAMPLE_W-1:0] filtI,
  input wire logic signed [SAMPLE_W-1:0] filtQ,
  input wire logic [1:0] askMode,
  input wire logic [1:0] manchesterMode,
  input wire logic [1:0][`RXBB_PAT_W-1:0] frame_start_pattern,
  input wire logic [1:0][`RXBB_PAT_LEN_W-1:0] patternLen,
  input wire logic [1:0][`RXBB_RSSI_W-1:0] rssiThreshold,
  input wire logic idCheckEnable,
  input wire logic tempMode,
  input wire logic tempValid,
  input wire logic [7:0] tempData,
  input wire logic [3:0] rssiReadIdx,
  output logic [`RXBB_RSSI_W-1:0] rssiReadData,
  output logic [4:0] rssiCount,
  output logic [1:0] raw_demod_out_per_path,
  output logic decoded_serial_out,
  output logic decoded_bit_clock_out,
  output logic [1:0][`RXBB_FOFS_W-1:0] rx_freq_offset_per_path,
  output logic [1:0] pathLocked,
  output logic selPath,
  output logic fifoValid,
  input wire logic fifoReady,
  output rxbb_byte_s fifoByte,
  output logic idValid,
  output rxbb_byte_s idByte
);
  // crc-8 over one byte, used by both paths
  function automatic logic [7:0] crcByte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int k = 0; k < 8; k++) begin
      c = c[7] ? ((c << 1) ^ `RXBB_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  logic [1:0] byteDone;
  logic [1:0][7:0] byteData;
  logic [1:0][7:0] byteCrc;
  logic [1:0] sigOk;
  logic [1:0][`RXBB_RSSI_W-1:0] pathRssi;
  logic [1:0] decBit;
  logic [1:0] decStrobe;
  logic bufInReady;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : gPath
      logic signed [SAMPLE_W-1:0] prevQ_q;
      logic [`RXBB_RSSI_W-1:0] mag;
      logic sym;
      logic [`RXBB_FOFS_W-1:0] fofs_q;
      logic [`RXBB_PAT_W-1:0] shift_q;
      logic [`RXBB_PAT_W-1:0] mask;
      rxbb_state_e state_q;
      logic half_q;
      logic firstSym_q;
      logic [2:0] bitCnt_q;
      logic [7:0] sh_q;
      logic [7:0] crc_q;
      logic [7:0] dat_q;
      logic done_q;
      logic bitStb;
      logic bitVal;

      // envelope and fm-discriminator demodulation from shared filter output
      assign mag = `RXBB_RSSI_W'((filtI[SAMPLE_W-1] ? -filtI : filtI) + (filtQ[SAMPLE_W-1] ? -filtQ : filtQ));
      assign sym = askMode[p] ? (mag > rssiThreshold[p]) : (filtQ > prevQ_q);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          prevQ_q <= '0;
          fofs_q <= '0;
        end else if (filtValid) begin
          prevQ_q <= filtQ;
          fofs_q <= `RXBB_FOFS_W'(filtQ - prevQ_q);
        end
      end
      assign sigOk[p] = (mag >= rssiThreshold[p]);
      assign pathRssi[p] = mag;
      assign rx_freq_offset_per_path[p] = fofs_q;

      // raw symbol pin
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) raw_demod_out_per_path[p] <= 1'b0;
        else if (filtValid) raw_demod_out_per_path[p] <= sym;
      end

      // start pattern search then payload
      assign mask = (patternLen[p] >= `RXBB_PAT_LEN_W'(32)) ? '1 :
                    ((`RXBB_PAT_W'(1) << patternLen[p]) - `RXBB_PAT_W'(1));
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          shift_q <= '0;
          state_q <= RXBB_HUNT;
        end else if (filtValid) begin
          shift_q <= {shift_q[`RXBB_PAT_W-2:0], sym};
          case (state_q)
            RXBB_HUNT: begin
              if ((({shift_q[`RXBB_PAT_W-2:0], sym} ^ frame_start_pattern[p]) & mask) == '0 && sigOk[p])
                state_q <= RXBB_PAYLOAD;
            end
            RXBB_PAYLOAD: begin
              if (!sigOk[p]) state_q <= RXBB_HUNT;
            end
            default: state_q <= RXBB_HUNT;
          endcase
        end
      end
      assign pathLocked[p] = (state_q == RXBB_PAYLOAD);

      // manchester pairs two symbols, nrz passes one
      assign bitStb = filtValid && pathLocked[p] && (!manchesterMode[p] || half_q);
      assign bitVal = manchesterMode[p] ? firstSym_q : sym;
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          half_q <= 1'b0;
          firstSym_q <= 1'b0;
        end else if (filtValid && pathLocked[p]) begin
          half_q <= manchesterMode[p] ? !half_q : 1'b0;
          firstSym_q <= sym;
        end else if (!pathLocked[p]) begin
          half_q <= 1'b0;
        end
      end
      assign decBit[p] = bitVal;
      assign decStrobe[p] = bitStb;

      // one-byte buffer with crc
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          bitCnt_q <= '0;
          sh_q <= '0;
          dat_q <= '0;
          crc_q <= `RXBB_CRC_INIT;
          done_q <= 1'b0;
        end else begin
          done_q <= 1'b0;
          if (!pathLocked[p]) begin
            bitCnt_q <= '0;
            crc_q <= `RXBB_CRC_INIT;
          end else if (bitStb) begin
            sh_q <= {sh_q[6:0], bitVal};
            bitCnt_q <= bitCnt_q + 3'd1;
            if (bitCnt_q == 3'd7) begin
              dat_q <= {sh_q[6:0], bitVal};
              crc_q <= crcByte(crc_q, {sh_q[6:0], bitVal});
              done_q <= 1'b1;
            end
          end
        end
      end
      assign byteDone[p] = done_q;
      assign byteData[p] = dat_q;
      assign byteCrc[p] = crc_q;
    end
  endgenerate

  // path selection by signal checks, held while selected path stays locked
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) selPath <= 1'b0;
    else if (!pathLocked[selPath] && pathLocked[!selPath] && sigOk[!selPath]) selPath <= !selPath;
  end

  // decoded serial output with bit clock from selected path
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      decoded_serial_out <= 1'b0;
      decoded_bit_clock_out <= 1'b0;
    end else begin
      decoded_bit_clock_out <= decStrobe[selPath];
      if (decStrobe[selPath]) decoded_serial_out <= decBit[selPath];
    end
  end

  // byte source: selected path or temperature sensor
  rxbb_byte_s inByte;
  logic inValid;
  always_comb begin
    if (tempMode) begin
      inValid = tempValid;
      inByte = '{data: tempData, crc: 8'h00, path: 1'b0, temp: 1'b1};
    end else begin
      inValid = byteDone[selPath];
      inByte = '{data: byteData[selPath], crc: byteCrc[selPath], path: selPath, temp: 1'b0};
    end
  end

  // two-entry buffer toward data fifo; a full buffer drops the arriving byte
  rxbb_byte_s buf_q [2];
  logic [1:0] cnt_q;
  logic rdPtr_q;
  logic wrPtr_q;
  logic push;
  logic pop;
  assign bufInReady = (cnt_q != 2'd2);
  assign push = inValid && bufInReady;
  assign pop = fifoValid && fifoReady;
  assign fifoValid = (cnt_q != 2'd0);
  assign fifoByte = buf_q[rdPtr_q];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      cnt_q <= '0;
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wrPtr_q] <= inByte;
        wrPtr_q <= !wrPtr_q;
      end
      if (pop) rdPtr_q <= !rdPtr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // copy to id check when enabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idValid <= 1'b0;
      idByte <= '0;
    end else begin
      idValid <= push && idCheckEnable && !inByte.temp;
      if (push) idByte <= inByte;
    end
  end

  // rssi buffer then circular support store of latest sixteen
  logic [RSSI_DEPTH-1:0][`RXBB_RSSI_W-1:0] rssiMem_q;
  logic [3:0] rssiWr_q;
  logic [`RXBB_RSSI_W-1:0] rssiBuf_q;
  logic rssiBufV_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rssiBuf_q <= '0;
      rssiBufV_q <= 1'b0;
    end else begin
      rssiBufV_q <= byteDone[selPath] && !tempMode;
      if (byteDone[selPath]) rssiBuf_q <= pathRssi[selPath];
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rssiMem_q <= '0;
      rssiWr_q <= '0;
      rssiCount <= '0;
    end else if (rssiBufV_q) begin
      rssiMem_q[rssiWr_q] <= rssiBuf_q;
      rssiWr_q <= rssiWr_q + 4'd1;
      if (rssiCount != 5'(RSSI_DEPTH)) rssiCount <= rssiCount + 5'd1;
    end
  end
  // index 0 is the newest value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rssiReadData <= '0;
    else rssiReadData <= rssiMem_q[rssiWr_q - 4'd1 - rssiReadIdx];
  end
endmodule
`default_nettype wire

//--- rxbb_checker.sv
// port assertions for the receive baseband
`timescale 1ns/1ps
`default_nettype none
`include "rxbb_params.svh"
module rxbb_checker
  import rxbb_pkg::*;
#(
  parameter int SAMPLE_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic filtValid,
  input wire logic signed [SAMPLE_W-1:0] filtI,
  input wire logic signed [SAMPLE_W-1:0] filtQ,
  input wire logic [1:0] askMode,
  input wire logic [1:0][`RXBB_RSSI_W-1:0] rssiThreshold,
  input wire logic idCheckEnable,
  input wire logic [4:0] rssiCount,
  input wire logic [1:0] raw_demod_out_per_path,
  input wire logic decoded_bit_clock_out,
  input wire logic [1:0] pathLocked,
  input wire logic selPath,
  input wire logic fifoValid,
  input wire logic fifoReady,
  input wire rxbb_byte_s fifoByte,
  input wire logic idValid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // buffer, path choice, pin pulses and rssi count
  fifo_hold_a: assert property (fifoValid && !fifoReady |=> fifoValid && $stable(fifoByte))
    else $error("stalled fifo word changed");
  sel_locked_a: assert property (selPath != $past(selPath) |-> pathLocked[selPath])
    else $error("switched to unlocked path");
  id_enable_a: assert property (idValid |-> $past(idCheckEnable) && fifoValid)
    else $error("id byte without enable");
  id_pulse_a: assert property (idValid |=> !idValid)
    else $error("id strobe too long");
  raw_sym_a: assert property (filtValid && askMode[0] && filtQ == 0 && filtI >= 0
    |=> raw_demod_out_per_path[0] == ($past(filtI) > $past(rssiThreshold[0])))
    else $error("raw symbol wrong");
  bitclk_pulse_a: assert property (decoded_bit_clock_out |=> !decoded_bit_clock_out)
    else $error("bit clock too long");
  rssi_cap_a: assert property (rssiCount <= 5'h10)
    else $error("rssi count over sixteen");
  rssi_step_a: assert property (rssiCount != $past(rssiCount) |-> rssiCount == $past(rssiCount) + 5'h01)
    else $error("rssi count jumped");
endmodule
bind rxbb_baseband rxbb_checker #(.SAMPLE_W(SAMPLE_W)) chk_u (.*);
`default_nettype wire

//--- rxbb_fifo_sink.sv
// data fifo side: pops words with random stalls
`timescale 1ns/1ps
`default_nettype none
module rxbb_fifo_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  output logic fifoReady
);
  int seed = 32'h1b2c3d4e;
  initial fifoReady = 1'b0;
  // ready drops one cycle in four, low while stalled
  always @(posedge mclk) begin
    #1 fifoReady = !rst && !stall && ($random(seed) % 4 != 0);
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the receive baseband
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rxbb_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic filtValid = 1'b0;
  logic signed [7:0] filtI = 8'sh00;
  logic signed [7:0] fq = 8'sh00;
  logic [1:0] man = 2'b00;
  logic tmode = 1'b0;
  logic tval = 1'b0;
  logic [7:0] tdat = 8'h00;
  logic [1:0][31:0] pat = {32'h0, 32'ha5};
  logic idEn = 1'b0;
  logic [3:0] rIdx = 4'h0;
  logic stall = 1'b0;
  logic fifoValid, fifoReady, idValid, selPath, dso, dbc;
  logic [7:0] rssiReadData;
  logic [4:0] rssiCount;
  logic [1:0] raw, locked;
  logic [1:0][7:0] fofs;
  rxbb_byte_s fifoByte, idByte;
  int miscompares = 0, samples_checked = 0, seed = 32'hd03afd33, crc = 8'hff, last = -1, expQ[$];
  int expId[$], rq[$], q = 0;
  always #12.5 mclk = ~mclk;
  rxbb_baseband dut_u (.mclk(mclk), .rst(rst), .filtValid(filtValid), .filtI(filtI), .filtQ(fq),
    .askMode(2'b01), .manchesterMode(man), .frame_start_pattern(pat), .patternLen({6'h08, 6'h08}),
    .rssiThreshold({8'h00, 8'h32}), .idCheckEnable(idEn), .tempMode(tmode), .tempValid(tval),
    .tempData(tdat), .rssiReadIdx(rIdx), .rssiReadData(rssiReadData), .rssiCount(rssiCount),
    .raw_demod_out_per_path(raw), .decoded_serial_out(dso), .decoded_bit_clock_out(dbc),
    .rx_freq_offset_per_path(fofs), .pathLocked(locked), .selPath(selPath), .fifoValid(fifoValid),
    .fifoReady(fifoReady), .fifoByte(fifoByte), .idValid(idValid), .idByte(idByte));
  rxbb_fifo_sink sink_u (.mclk(mclk), .rst(rst), .stall(stall), .fifoReady(fifoReady));
  task automatic chk(input logic [17:0] got, input int e);
    samples_checked++;
    if (e < 0 || got !== e[17:0]) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one ask symbol every other cycle
  task automatic sym(input logic b);
    @(posedge mclk);
    #1 filtValid = 1'b1;
    filtI = b ? 8'sd100 : 8'sd50; // weak carrier for zero still passes the signal check
    rIdx = 4'($random(seed));
    @(posedge mclk);
    #1 filtValid = 1'b0;
    chk({17'h0, raw[0]}, b);
  endtask
  // msb first byte, running crc8 poly 07; manchester adds the inverted second symbol
  task automatic send(input logic [7:0] v, input bit keep);
    for (int i = 7; i >= 0; i--) begin
      sym(v[i]);
      if (man[0]) sym(!v[i]);
      chk({16'h0, dbc, dso}, 2 + int'(v[i]));
    end
    crc = crc ^ v;
    for (int i = 0; i < 8; i++) crc = (crc[7] ? (crc << 1) ^ 8'h07 : crc << 1) & 8'hff;
    last = {v, crc[7:0], 2'b00};
    // let the push edge pass before the id enable may change
    @(posedge mclk);
    #1;
    if (keep) expQ.push_back(last);
    if (keep && idEn) expId.push_back(last);
    rq.push_back((man[0] ? !v[0] : v[0]) ? 100 : 50);
  endtask
  task automatic drain;
    for (int k = 0; k < 400 && expQ.size() > 0; k++) @(posedge mclk);
    #1;
  endtask
  // pops and id copies against the model
  always @(posedge mclk) begin
    if (!rst && fifoValid && fifoReady) chk(fifoByte, expQ.size() ? expQ.pop_front() : -1);
    if (!rst && idValid) chk(idByte, expId.size() ? expId.pop_front() : -1);
  end
  initial begin
    #500000;
    miscompares++;
    $display("[ERR] %0t timeout", $time);
    stop_test;
  end
  initial begin
    pat[1] = $random(seed) | 32'h1;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (12) sym(1'b0);
    for (int i = 7; i >= 0; i--) sym(pat[0][i]);
    for (int n = 0; n < 12; n++) begin
      idEn = 1'($random(seed));
      send(8'($random(seed)), 1'b1);
    end
    drain;
    idEn = 1'b0;
    stall = 1'b1;
    send(8'h00, 1'b1);
    send(8'hff, 1'b1);
    send(8'h5a, 1'b0); // buffer full, word dropped
    repeat (6) @(posedge mclk);
    #1 stall = 1'b0;
    man = 2'b01;
    for (int n = 0; n < 8; n++) send(8'($random(seed)), 1'b1);
    drain;
    chk({13'h0, rssiCount}, 16);
    chk({17'h0, expQ.size() == 0}, 1);
    chk({17'h0, expId.size() == 0}, 1);
    // newest sixteen rssi values, index 0 newest
    for (int k = 0; k < 16; k++) begin
      rIdx = 4'(k);
      @(posedge mclk);
      #1 chk({10'h0, rssiReadData}, rq[rq.size() - 1 - k]);
    end
    // temperature word replaces path bytes
    tmode = 1'b1;
    tdat = 8'($random(seed));
    expQ.push_back({tdat, 8'h00, 2'b01});
    @(posedge mclk);
    #1 tval = 1'b1;
    @(posedge mclk);
    #1 tval = 1'b0;
    drain;
    chk({17'h0, expQ.size() == 0}, 1);
    tmode = 1'b0;
    // weak fsk burst: first path fails its check, second path finds its pattern
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      #1 filtValid = 1'b1;
      filtI = 8'sd0;
      q = q + (pat[1][i] ? 1 : -1);
      fq = 8'(q);
      @(posedge mclk);
      #1 filtValid = 1'b0;
      chk({17'h0, raw[1]}, pat[1][i]);
      chk({10'h0, fofs[1]}, pat[1][i] ? 1 : 255);
    end
    @(posedge mclk);
    #1 chk({17'h0, selPath}, 1);
    stop_test;
  end
endmodule
`default_nettype wire
